// [pkg/pwmtb_pkg.sv]
// pwmtb_pkg: register map, field positions, encodings and carrier types of the timer base counter.
// assumes a plain register port with 4-bit word index and 16-bit data.
package pwmtb_pkg;
    localparam int unsigned ADDR_W = 4;
    localparam int unsigned DATA_W = 16;
    localparam int unsigned NCMP   = 3;

    // register word indices
    localparam logic [3:0] REG_CONTROL_FIRST  = 4'h0;
    localparam logic [3:0] REG_CONTROL_SECOND = 4'h1;
    localparam logic [3:0] REG_CONTROL_FIFTH  = 4'h2;
    localparam logic [3:0] REG_CONTROL_SIXTH  = 4'h3;
    localparam logic [3:0] REG_EVENT_CONTROL  = 4'h4;
    localparam logic [3:0] REG_STATUS         = 4'h5;
    localparam logic [3:0] REG_COUNTER        = 4'h6;
    localparam logic [3:0] REG_PERIOD         = 4'h7;
    localparam logic [3:0] REG_COMPARE0       = 4'h8;
    localparam logic [3:0] REG_PERIOD_STAGING = 4'hb;
    localparam logic [3:0] REG_COMPARE_STG0   = 4'hc;

    // field positions
    localparam int unsigned F_ENABLE      = 0;
    localparam int unsigned F_PRESCALE_LO = 1;
    localparam int unsigned F_UPD_FLOOR   = 0;
    localparam int unsigned F_SPLIT       = 1;
    localparam int unsigned F_DIR_DOWN    = 0;
    localparam int unsigned F_LOCK        = 1;
    localparam int unsigned F_CNT_EVT_EN  = 0;
    localparam int unsigned F_EVT_ACT_LO  = 1;

    localparam logic [15:0] RESET_VALUE = 16'h0000;
    localparam logic [15:0] COUNT_FLOOR = 16'h0000;
    localparam logic [7:0]  FLOOR_BYTE  = 8'h00;
    localparam int unsigned PRE_W       = 10;

    // event actions when the count event input is enabled
    localparam logic [1:0] EVT_ACT_COUNT   = 2'h0;
    localparam logic [1:0] EVT_ACT_DIR     = 2'h1;
    localparam logic [1:0] EVT_ACT_RESTART = 2'h2;

    typedef enum logic [1:0] {
        ST_HALT = 2'b01,
        ST_RUN  = 2'b10
    } pwmtb_state_t;

    typedef struct packed {
        logic       top;
        logic       floor;
        logic [5:0] match;
    } pwmtb_hit_t;

    // prescaler mask: tick when the masked prescale count is all ones
    function automatic logic [9:0] pwmtb_pre_mask(input logic [2:0] sel);
        case (sel)
            3'h0:    return 10'h000;
            3'h1:    return 10'h001;
            3'h2:    return 10'h003;
            3'h3:    return 10'h007;
            3'h4:    return 10'h00f;
            3'h5:    return 10'h03f;
            3'h6:    return 10'h0ff;
            default: return 10'h3ff;
        endcase
    endfunction
endpackage

// [rtl/pwmtb_base_counter.sv]
// pwmtb_base_counter: base counter, period and three compare channels with staging registers.
// assumes register strobes and event input synchronous to clk_sys; strobes never both high.
//
// The address-and-strobe port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

module pwmtb_base_counter (
    input  wire logic               clk_sys,
    input  wire logic               rst_n,
    input  wire logic [3:0]         reg_addr,
    input  wire logic [15:0]        reg_wdata,
    input  wire logic               reg_wr,
    input  wire logic               reg_rd,
    output logic [15:0]             reg_rdata,
    input  wire logic               event_in,
    output pwmtb_pkg::pwmtb_hit_t   hit_pulse,
    output logic [5:0]              waveform_out_n,
    output logic                    counting
);
    pwmtb_pkg::pwmtb_state_t state_reg;
    logic [2:0]   prescale_select;
    logic         enable_reg;
    logic         upd_floor_reg;
    logic         split_reg;
    logic         dir_down_reg;
    logic         lock_transfer;
    logic         count_event_input_enable;
    logic [1:0]   evt_action_reg;
    logic [15:0]  counter_reg;
    logic [15:0]  counter_next;
    logic [15:0]  period_reg;
    logic [15:0]  period_staging;
    logic [2:0][15:0] compare_value_n;
    logic [2:0][15:0] compare_staging_n;
    logic         period_staging_valid;
    logic [2:0]   compare_staging_valid_n;
    logic [9:0]   pre_cnt_reg;
    logic         evt_prev_reg;
    logic         evt_edge;
    logic         pre_tick;
    logic         timer_tick;
    logic         restart;
    logic         dir_eff;
    logic         top_hit;
    logic         floor_hit;
    logic         hi_floor_hit;
    logic [5:0]   match_now;
    logic         update_now;
    logic         wr_cnt;
    logic         wr_per_stg;
    logic [2:0]   wr_cmp;
    logic [2:0]   wr_cmp_stg;
    logic [15:0]  rdata_next;

    assign wr_cnt     = reg_wr && (reg_addr == pwmtb_pkg::REG_COUNTER);
    assign wr_per_stg = reg_wr && (reg_addr == pwmtb_pkg::REG_PERIOD_STAGING);

    genvar g;
    generate
        for (g = 0; g < 3; g++)
        begin : g_dec
            assign wr_cmp[g]     = reg_wr && (reg_addr == pwmtb_pkg::REG_COMPARE0 + 4'(g));
            assign wr_cmp_stg[g] = reg_wr && (reg_addr == pwmtb_pkg::REG_COMPARE_STG0 + 4'(g));
            // low half channels in split use the low byte, 16-bit mode uses the whole word
            assign match_now[g] = split_reg ? (counter_reg[7:0] == compare_value_n[g][7:0])
                                            : (counter_reg == compare_value_n[g]);
            assign match_now[g+3] = split_reg && (counter_reg[15:8] == compare_value_n[g][15:8]);
        end
    endgenerate

    // tick source and event handling
    assign evt_edge = event_in && !evt_prev_reg;
    assign pre_tick = (state_reg == pwmtb_pkg::ST_RUN)
                      && ((pre_cnt_reg & pwmtb_pkg::pwmtb_pre_mask(prescale_select))
                          == pwmtb_pkg::pwmtb_pre_mask(prescale_select));
    always_comb
    begin
        timer_tick = pre_tick;
        restart    = 1'b0;
        dir_eff    = dir_down_reg;
        if (count_event_input_enable)
        begin
            case (evt_action_reg)
                pwmtb_pkg::EVT_ACT_COUNT:   timer_tick = (state_reg == pwmtb_pkg::ST_RUN) && evt_edge;
                pwmtb_pkg::EVT_ACT_DIR:     dir_eff = dir_down_reg ^ event_in;
                pwmtb_pkg::EVT_ACT_RESTART: restart = (state_reg == pwmtb_pkg::ST_RUN) && evt_edge;
                default:                    timer_tick = pre_tick;
            endcase
        end
    end

    // top is the period in 16-bit mode, the highest value of the sequence, and a zero low byte in split; all ones is just a period of max
    assign top_hit      = split_reg ? (counter_reg[7:0] == pwmtb_pkg::FLOOR_BYTE)
                                    : (counter_reg == period_reg);
    assign floor_hit    = split_reg ? (counter_reg[7:0] == pwmtb_pkg::FLOOR_BYTE)
                                    : (counter_reg == pwmtb_pkg::COUNT_FLOOR);
    assign hi_floor_hit = split_reg && (counter_reg[15:8] == pwmtb_pkg::FLOOR_BYTE);
    assign update_now   = timer_tick && !lock_transfer && !split_reg
                          && (upd_floor_reg ? floor_hit : top_hit);

    always_comb
    begin
        counter_next = counter_reg;
        if (restart)
        begin
            counter_next = dir_eff ? period_reg : pwmtb_pkg::COUNT_FLOOR;
        end
        else if (timer_tick)
        begin
            if (split_reg)
            begin
                // split halves only count down and reload from their period byte
                counter_next[7:0]  = (counter_reg[7:0] == pwmtb_pkg::FLOOR_BYTE)
                                     ? period_reg[7:0] : counter_reg[7:0] - 8'h01;
                counter_next[15:8] = (counter_reg[15:8] == pwmtb_pkg::FLOOR_BYTE)
                                     ? period_reg[15:8] : counter_reg[15:8] - 8'h01;
            end
            else if (dir_eff)
            begin
                counter_next = floor_hit ? period_reg : counter_reg - 16'h0001;
            end
            else
            begin
                counter_next = top_hit ? pwmtb_pkg::COUNT_FLOOR : counter_reg + 16'h0001;
            end
        end
        if (wr_cnt)
        begin
            counter_next = reg_wdata;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            counter_reg <= pwmtb_pkg::RESET_VALUE;
        end
        else
        begin
            counter_reg <= counter_next;
        end
    end

    // run state follows the enable control
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            state_reg <= pwmtb_pkg::ST_HALT;
        end
        else
        begin
            case (state_reg)
                pwmtb_pkg::ST_HALT: if (enable_reg) state_reg <= pwmtb_pkg::ST_RUN;
                pwmtb_pkg::ST_RUN:  if (!enable_reg) state_reg <= pwmtb_pkg::ST_HALT;
                default:            state_reg <= pwmtb_pkg::ST_HALT;
            endcase
        end
    end

    // prescaler restarts from zero while halted so the first period is whole
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            pre_cnt_reg  <= 10'h000;
            evt_prev_reg <= 1'b0;
        end
        else
        begin
            pre_cnt_reg  <= (state_reg == pwmtb_pkg::ST_RUN) ? pre_cnt_reg + 10'h001 : 10'h000;
            evt_prev_reg <= event_in;
        end
    end

    // control registers
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            enable_reg               <= 1'b0;
            prescale_select          <= 3'h0;
            upd_floor_reg            <= 1'b0;
            split_reg                <= 1'b0;
            dir_down_reg             <= 1'b0;
            lock_transfer            <= 1'b0;
            count_event_input_enable <= 1'b0;
            evt_action_reg           <= 2'h0;
        end
        else if (reg_wr)
        begin
            case (reg_addr)
                pwmtb_pkg::REG_CONTROL_FIRST:
                begin
                    enable_reg      <= reg_wdata[pwmtb_pkg::F_ENABLE];
                    prescale_select <= reg_wdata[pwmtb_pkg::F_PRESCALE_LO +: 3];
                end
                pwmtb_pkg::REG_CONTROL_SECOND:
                begin
                    upd_floor_reg <= reg_wdata[pwmtb_pkg::F_UPD_FLOOR];
                    split_reg     <= reg_wdata[pwmtb_pkg::F_SPLIT];
                end
                pwmtb_pkg::REG_CONTROL_FIFTH:
                begin
                    dir_down_reg  <= reg_wdata[pwmtb_pkg::F_DIR_DOWN];
                    lock_transfer <= reg_wdata[pwmtb_pkg::F_LOCK];
                end
                pwmtb_pkg::REG_EVENT_CONTROL:
                begin
                    count_event_input_enable <= reg_wdata[pwmtb_pkg::F_CNT_EVT_EN];
                    evt_action_reg           <= reg_wdata[pwmtb_pkg::F_EVT_ACT_LO +: 2];
                end
                default:
                begin
                end
            endcase
        end
    end

    // period and staging; a staging write in the update cycle keeps its valid flag
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            period_reg           <= pwmtb_pkg::RESET_VALUE;
            period_staging       <= pwmtb_pkg::RESET_VALUE;
            period_staging_valid <= 1'b0;
        end
        else
        begin
            if (reg_wr && (reg_addr == pwmtb_pkg::REG_PERIOD))
            begin
                period_reg <= reg_wdata;
            end
            else if (update_now && period_staging_valid)
            begin
                period_reg <= period_staging;
            end
            if (wr_per_stg)
            begin
                period_staging       <= reg_wdata;
                period_staging_valid <= 1'b1;
            end
            else if (update_now)
            begin
                period_staging_valid <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            compare_value_n         <= '0;
            compare_staging_n       <= '0;
            compare_staging_valid_n <= 3'h0;
        end
        else
        begin
            for (int n = 0; n < 3; n++)
            begin
                if (wr_cmp[n])
                begin
                    compare_value_n[n] <= reg_wdata;
                end
                else if (update_now && compare_staging_valid_n[n])
                begin
                    compare_value_n[n] <= compare_staging_n[n];
                end
                if (wr_cmp_stg[n])
                begin
                    compare_staging_n[n]       <= reg_wdata;
                    compare_staging_valid_n[n] <= 1'b1;
                end
                else if (update_now)
                begin
                    compare_staging_valid_n[n] <= 1'b0;
                end
            end
        end
    end

    // hits seen at a tick are pulsed for one cycle right after it, from the value the counter held at that tick
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            hit_pulse <= '0;
        end
        else if (timer_tick)
        begin
            hit_pulse.top   <= top_hit;
            hit_pulse.floor <= split_reg ? hi_floor_hit : floor_hit;
            hit_pulse.match <= match_now;
        end
        else
        begin
            hit_pulse <= '0;
        end
    end

    // single-slope style output: set at floor, cleared on match; match wins so compare at floor stays low
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            waveform_out_n <= 6'h00;
        end
        else if (timer_tick)
        begin
            for (int n = 0; n < 6; n++)
            begin
                if (match_now[n])
                begin
                    waveform_out_n[n] <= 1'b0;
                end
                else if ((n < 3) ? floor_hit : hi_floor_hit)
                begin
                    waveform_out_n[n] <= 1'b1;
                end
            end
        end
    end

    always_comb
    begin
        rdata_next = 16'h0000;
        case (reg_addr)
            pwmtb_pkg::REG_CONTROL_FIRST:  rdata_next = {12'h000, prescale_select, enable_reg};
            pwmtb_pkg::REG_CONTROL_SECOND: rdata_next = {14'h0000, split_reg, upd_floor_reg};
            pwmtb_pkg::REG_CONTROL_FIFTH:  rdata_next = {14'h0000, lock_transfer, dir_down_reg};
            pwmtb_pkg::REG_CONTROL_SIXTH:  rdata_next = {12'h000, compare_staging_valid_n, period_staging_valid};
            pwmtb_pkg::REG_EVENT_CONTROL:  rdata_next = {13'h0000, evt_action_reg, count_event_input_enable};
            pwmtb_pkg::REG_STATUS:         rdata_next = {6'h00, match_now, floor_hit, top_hit, dir_eff,
                                                         (state_reg == pwmtb_pkg::ST_RUN)};
            pwmtb_pkg::REG_COUNTER:        rdata_next = counter_reg;
            pwmtb_pkg::REG_PERIOD:         rdata_next = period_reg;
            4'h8:                          rdata_next = compare_value_n[0];
            4'h9:                          rdata_next = compare_value_n[1];
            4'ha:                          rdata_next = compare_value_n[2];
            pwmtb_pkg::REG_PERIOD_STAGING: rdata_next = period_staging;
            4'hc:                          rdata_next = compare_staging_n[0];
            4'hd:                          rdata_next = compare_staging_n[1];
            4'he:                          rdata_next = compare_staging_n[2];
            default:                       rdata_next = 16'h0000;
        endcase
    end

    // read data stand only in the cycle after the strobe
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            reg_rdata <= 16'h0000;
            counting  <= 1'b0;
        end
        else
        begin
            reg_rdata <= reg_rd ? rdata_next : 16'h0000;
            counting  <= (state_reg == pwmtb_pkg::ST_RUN);
        end
    end
endmodule // pwmtb_base_counter

`default_nettype wire

// [sim/pwmtb_base_counter_props.sv]
// pwmtb_base_counter_props: port-level checks of the timer base counter.
// assumes it is bound to pwmtb_base_counter and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none

module pwmtb_base_counter_props (
    input wire logic                  clk_sys,
    input wire logic                  rst_n,
    input wire logic [3:0]            reg_addr,
    input wire logic [15:0]           reg_wdata,
    input wire logic                  reg_wr,
    input wire logic                  reg_rd,
    input wire logic [15:0]           reg_rdata,
    input wire logic                  event_in,
    input wire pwmtb_pkg::pwmtb_hit_t hit_pulse,
    input wire logic [5:0]            waveform_out_n,
    input wire logic                  counting
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    property p_rdata_idle;
        !reg_rd |=> reg_rdata == 16'h0000;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data not zero outside read slot");

    property p_unmapped;
        reg_rd && reg_addr == 4'hf |=> reg_rdata == 16'h0000;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped slot returned data");

    property p_cnt_write;
        reg_wr && reg_addr == pwmtb_pkg::REG_COUNTER ##1 reg_rd && reg_addr == pwmtb_pkg::REG_COUNTER
            |=> reg_rdata == $past(reg_wdata, 2);
    endproperty
    a_cnt_write: assert property (p_cnt_write) else $error("counter write did not take effect at once");

    property p_per_write;
        reg_wr && reg_addr == pwmtb_pkg::REG_PERIOD ##1 reg_rd && reg_addr == pwmtb_pkg::REG_PERIOD
            |=> reg_rdata == $past(reg_wdata, 2);
    endproperty
    a_per_write: assert property (p_per_write) else $error("direct period write not immediate");

    property p_valid_set;
        reg_wr && reg_addr == pwmtb_pkg::REG_PERIOD_STAGING ##1 reg_rd && reg_addr == pwmtb_pkg::REG_CONTROL_SIXTH
            |=> reg_rdata[0];
    endproperty
    a_valid_set: assert property (p_valid_set) else $error("staging valid flag not set by write");

    property p_enable_start;
        reg_wr && reg_addr == pwmtb_pkg::REG_CONTROL_FIRST && reg_wdata[0] |-> ##[1:3] counting;
    endproperty
    a_enable_start: assert property (p_enable_start) else $error("enable did not start the counter");

    // three idle cycles leave no tick in flight, so nothing may move
    property p_halt_quiet;
        !counting [*3] |-> hit_pulse == '0 && $stable(waveform_out_n);
    endproperty
    a_halt_quiet: assert property (p_halt_quiet) else $error("activity while halted");

    property p_hit_run;
        hit_pulse != '0 |-> counting;
    endproperty
    a_hit_run: assert property (p_hit_run) else $error("hit pulse without a running counter");

    property p_match_clear;
        hit_pulse.match[0] |-> !waveform_out_n[0];
    endproperty
    a_match_clear: assert property (p_match_clear) else $error("match did not clear waveform");
endmodule // pwmtb_base_counter_props

bind pwmtb_base_counter pwmtb_base_counter_props u_pwmtb_base_counter_props (.clk_sys, .rst_n, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .event_in, .hit_pulse, .waveform_out_n, .counting);

`default_nettype wire

// [sim/pwmtb_event_src.sv]
// pwmtb_event_src: behavioural event channel feeding the counter's event input.
// assumes fire is a one-cycle request; the bench waits until the line is low again.
`timescale 1ns/1ps
`default_nettype none

module pwmtb_event_src (
    input  wire logic       clk_sys,
    input  wire logic       rst_n,
    input  wire logic       fire,
    input  wire logic [3:0] hold,
    output logic            event_in
);
    logic [3:0] cnt_reg;

    // long holds check that a level counts once, only its rising edge
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
            cnt_reg <= 4'h0;
        else if (fire)
            cnt_reg <= hold;
        else if (cnt_reg != 4'h0)
            cnt_reg <= cnt_reg - 4'h1;
    end

    assign event_in = (cnt_reg != 4'h0);
endmodule // pwmtb_event_src

`default_nettype wire

// [sim/tb_top.sv]
// tb_top: self-checking bench of the timer base counter.
// assumes the checker is bound by its own file; event source model drives event_in.
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    logic                  clk_sys = 1'b0;
    logic                  rst_n = 1'b0;
    logic [3:0]            reg_addr = 4'h0;
    logic [15:0]           reg_wdata = 16'h0000;
    logic                  reg_wr = 1'b0;
    logic                  reg_rd = 1'b0;
    logic [15:0]           reg_rdata;
    logic                  event_in;
    logic                  fire = 1'b0;
    logic [3:0]            hold = 4'h1;
    pwmtb_pkg::pwmtb_hit_t hit_pulse;
    logic [5:0]            waveform_out_n;
    logic                  counting;
    int                    n_fail = 0;
    int                    check_count = 0;
    int                    cyc = 0;
    int                    n_top = 0;
    int                    n_floor = 0;
    int                    n_match = 0;
    int                    nchg;
    logic [31:0]           seed = 32'he983;
    logic [15:0]           q;
    logic [15:0]           r;
    logic [15:0]           per;
    logic [15:0]           cmp;

    always #12.5 clk_sys = ~clk_sys;

    pwmtb_base_counter u_pwmtb_base_counter (.clk_sys, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .event_in, .hit_pulse, .waveform_out_n, .counting);
    pwmtb_event_src u_pwmtb_event_src (.clk_sys, .rst_n, .fire, .hold, .event_in);

    task automatic give_verdict();
        if (n_fail == 0 && check_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    always @(posedge clk_sys)
    begin
        cyc <= cyc + 1;
        n_top <= n_top + int'(hit_pulse.top === 1'b1);
        n_floor <= n_floor + int'(hit_pulse.floor === 1'b1);
        n_match <= n_match + int'(hit_pulse.match[0] === 1'b1);
        if (cyc == 20000)
        begin
            n_fail++;
            give_verdict();
        end
    end

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    function automatic logic [15:0] nxt(input logic [15:0] v, input logic [15:0] p, input logic dn);
        if (dn)
            return (v == 16'h0000) ? p : v - 16'h0001;
        return (v == p) ? 16'h0000 : v + 16'h0001;
    endfunction

    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // one bus cycle; rd is the read data of the cycle before
    task automatic bus(input logic w, input logic rs, input logic [3:0] a, input logic [15:0] d,
                       output logic [15:0] rd);
        reg_wr <= w;
        reg_rd <= rs;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        rd = reg_rdata;
    endtask

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        bus(1'b1, 1'b0, a, d, q);
    endtask

    task automatic rdreg(input logic [3:0] a, output logic [15:0] v);
        bus(1'b0, 1'b1, a, 16'h0000, q);
        bus(1'b0, 1'b0, 4'h0, 16'h0000, v);
    endtask

    task automatic idle(input int n);
        repeat (n) bus(1'b0, 1'b0, 4'h0, 16'h0000, q);
    endtask

    task automatic evt(input logic [3:0] h);
        hold <= h;
        fire <= 1'b1;
        @(posedge clk_sys);
        fire <= 1'b0;
    endtask

    // back-to-back counter reads: always counts changes, and with step also checks each move
    task automatic seq(input int n, input logic dn, input logic step);
        logic [15:0] a;
        logic [15:0] b;
        nchg = 0;
        bus(1'b0, 1'b1, pwmtb_pkg::REG_COUNTER, 16'h0000, q);
        for (int i = 0; i < n; i++)
        begin
            bus(1'b0, i < n - 1, pwmtb_pkg::REG_COUNTER, 16'h0000, b);
            if (i > 0 && step)
                chk("counter step", b, nxt(a, per, dn));
            if (i > 0 && b !== a)
                nchg++;
            a = b;
        end
    endtask

    initial
    begin
        int t0;
        int f0;
        int m0;
        logic [15:0] e;
        repeat (10) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(posedge clk_sys);
        for (int a = 0; a < 16; a++)
        begin
            rdreg(4'(a), r);
            // status shows live hits of a zero counter against zero period and compares
            chk("reset value", r, (a == 5) ? 16'h007c : 16'h0000);
        end
        per = 16'h0002 + 16'(rnd() % 6);
        cmp = 16'(rnd() % 32'(per));
        for (int a = 7; a < 15; a++)
        begin
            e = (a == 11) ? per : (a == 12) ? cmp : 16'(rnd());
            wr(4'(a), e);
            rdreg(4'(a), r);
            chk("register readback", r, e);
        end
        wr(pwmtb_pkg::REG_PERIOD, per);
        wr(pwmtb_pkg::REG_COMPARE0, cmp);
        wr(pwmtb_pkg::REG_CONTROL_SIXTH, 16'h0000);
        wr(4'hf, 16'hffff);
        rdreg(pwmtb_pkg::REG_CONTROL_SIXTH, r);
        chk("valid flags", r, 16'h000f);
        wr(pwmtb_pkg::REG_CONTROL_FIRST, 16'h0001);
        idle(4);
        seq(3 * int'(per) + 5, 1'b0, 1'b1);
        rdreg(pwmtb_pkg::REG_CONTROL_SIXTH, r);
        chk("valid after update", r, 16'h0000);
        t0 = n_top;
        f0 = n_floor;
        m0 = n_match;
        idle(4 * (int'(per) + 1));
        chk("top pulses", 16'(n_top - t0), 16'h0004);
        chk("floor pulses", 16'(n_floor - f0), 16'h0004);
        chk("match pulses", 16'(n_match - m0), 16'h0004);
        wr(pwmtb_pkg::REG_COUNTER, per);
        rdreg(pwmtb_pkg::REG_COUNTER, r);
        chk("running counter write", r, per);
        wr(pwmtb_pkg::REG_CONTROL_FIFTH, 16'h0001);
        idle(2);
        seq(2 * int'(per) + 4, 1'b1, 1'b1);
        // locked: staged period must wait
        wr(pwmtb_pkg::REG_CONTROL_FIFTH, 16'h0003);
        wr(pwmtb_pkg::REG_PERIOD_STAGING, per + 16'h0001);
        rdreg(pwmtb_pkg::REG_CONTROL_SIXTH, r);
        chk("staged valid", r, 16'h0001);
        wr(pwmtb_pkg::REG_COMPARE_STG0, per);
        idle(3 * int'(per) + 6);
        rdreg(pwmtb_pkg::REG_PERIOD, r);
        chk("locked period", r, per);
        rdreg(pwmtb_pkg::REG_CONTROL_SIXTH, r);
        chk("locked valid", r, 16'h0003);
        wr(pwmtb_pkg::REG_CONTROL_FIFTH, 16'h0001);
        idle(3 * int'(per) + 6);
        per = per + 16'h0001;
        rdreg(pwmtb_pkg::REG_PERIOD, r);
        chk("staged period", r, per);
        rdreg(pwmtb_pkg::REG_COMPARE0, r);
        chk("staged compare", r, per - 16'h0001);
        rdreg(pwmtb_pkg::REG_CONTROL_SIXTH, r);
        chk("valid cleared", r, 16'h0000);
        wr(pwmtb_pkg::REG_CONTROL_FIFTH, 16'h0000);
        for (int s = 0; s < 7; s++)
        begin
            t0 = (s < 5) ? (1 << s) : (1 << (2 * s - 4));
            wr(pwmtb_pkg::REG_CONTROL_FIRST, 16'((s << 1) | 1));
            idle(2 * t0);
            seq(2 * t0 + 1, 1'b0, 1'b0);
            chk("prescaled ticks", 16'(nchg), 16'h0002);
        end
        wr(pwmtb_pkg::REG_EVENT_CONTROL, 16'h0001);
        idle(2);
        rdreg(pwmtb_pkg::REG_COUNTER, e);
        for (int i = 0; i < 5; i++)
        begin
            evt((i % 2 == 1) ? 4'h5 : 4'h1);
            idle(7);
            e = nxt(e, per, 1'b0);
        end
        rdreg(pwmtb_pkg::REG_COUNTER, r);
        chk("event count", r, e);
        // halt and re-enable at divide 1024 so no prescaled tick lands in what follows
        wr(pwmtb_pkg::REG_CONTROL_FIRST, 16'h000e);
        wr(pwmtb_pkg::REG_CONTROL_FIRST, 16'h000f);
        wr(pwmtb_pkg::REG_EVENT_CONTROL, 16'h0005);
        wr(pwmtb_pkg::REG_COUNTER, 16'h0003);
        evt(4'h1);
        idle(3);
        rdreg(pwmtb_pkg::REG_COUNTER, r);
        chk("event restart", r, 16'h0000);
        wr(pwmtb_pkg::REG_EVENT_CONTROL, 16'h0003);
        evt(4'h5);
        rdreg(pwmtb_pkg::REG_STATUS, r);
        chk("event direction", 16'(r[1]), 16'h0001);
        wr(pwmtb_pkg::REG_CONTROL_SECOND, 16'h0002);
        wr(pwmtb_pkg::REG_EVENT_CONTROL, 16'h0001);
        wr(pwmtb_pkg::REG_COUNTER, 16'h0100);
        idle(4);
        evt(4'h1);
        idle(3);
        rdreg(pwmtb_pkg::REG_COUNTER, r);
        chk("split count", r, per);
        give_verdict();
    end
endmodule // tb_top

`default_nettype wire
